// ### hdl/eau_map.svh
// Offsets, field positions, opcodes, reset values and timing counts of the
// arithmetic extension unit. Assumes it is included by the unit's module.
`ifndef EAU_MAP_SVH
`define EAU_MAP_SVH

// Register byte offsets on the AHB-Lite bus.
`define EAU_ADDR_INSTR   8'h00
`define EAU_ADDR_OPERAND 8'h04
`define EAU_ADDR_AC      8'h08
`define EAU_ADDR_MQ      8'h0c
`define EAU_ADDR_STATUS  8'h10

// Status word fields.
`define EAU_ST_LINK      0
`define EAU_ST_SC_LO     1
`define EAU_ST_ACTIVE    6
`define EAU_ST_HOLD      7
`define EAU_ST_BUSY      8
`define EAU_ST_SUB_LO    9

// Operation select, instruction bits 08 to 10 (bit 00 is the MSB).
`define EAU_OP_ASR       3'h6
`define EAU_OP_LSR       3'h7
`define EAU_OP_SHL       3'h5
`define EAU_OP_MUY       3'h2
`define EAU_OP_DVI       3'h3

// Step counter figures.
`define EAU_SC_FULL      5'h1f
`define EAU_MUY_END      5'h0c
`define EAU_DVI_END      5'h0d

// Reset values.
`define EAU_WORD_RST     12'h000
`define EAU_SC_RST       5'h00

// Hold release delay after timing ends: least time, rounded up to cycles.
`define EAU_CLK_MHZ      10
`define EAU_RELEASE_NS   50
`define EAU_RELEASE_CYC  ((`EAU_RELEASE_NS * `EAU_CLK_MHZ + 999) / 1000)

`endif

// ### hdl/eau_pkg.sv
// Types of the arithmetic extension unit: sequencer states, data word and
// the captured AHB-Lite address phase. Assumes no other package.
`default_nettype none

package eau_pkg;

	// Sequencer states.
	typedef enum logic [2:0] {
		EAU_IDLE,
		EAU_FETCH,
		EAU_EXEC,
		EAU_RUN,
		EAU_DONE,
		EAU_RELEASE
	} eau_state_t;

	// One 12-bit machine word.
	typedef logic [11:0] eau_word_t;

	// Address phase held over into the data phase.
	typedef struct packed {
		logic       sel;
		logic       write;
		logic [7:0] addr;
	} eau_aphase_t;

endpackage : eau_pkg

`default_nettype wire

// ### hdl/eau_sequencer.sv
// Shift, multiply and divide sequencer with its accumulator, extension
// register, carry bit and 5-bit step counter, reached over AHB-Lite.
// Assumes a single-word AHB-Lite master and a processor timing pulse pin.
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`include "eau_map.svh"
`default_nettype none

module eau_sequencer
	import eau_pkg::*;
(
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave port.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Processor timing.
	input  wire logic        third_timing_pulse,
	output logic             phase_five_hold,
	output logic             extension_timing_active,
	output logic             multiplicand_add_enable
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations.

	eau_state_t  state;
	eau_aphase_t aph;
	eau_word_t   instr;
	eau_word_t   operand;
	eau_word_t   ac;
	eau_word_t   mq;
	logic        link;
	logic [4:0]  sc;
	logic [3:0]  subfield;
	logic        exec_flag;
	logic [1:0]  rel_cnt;
	logic        tp_meta;
	logic        tp_sync;
	logic        tp_prev;
	logic        tp_edge;
	logic        wr_en;
	logic        start_wr;
	logic [2:0]  op;
	logic        is_shift;
	logic [12:0] mul_sum;
	logic [12:0] div_rem;
	logic [12:0] div_diff;
	logic        div_fit;
	logic        div_ovf;
	logic [31:0] status;

	////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Only the five timed operations may be started.
	function automatic logic op_legal(input logic [2:0] sel);
		op_legal = (sel == `EAU_OP_ASR) || (sel == `EAU_OP_LSR) ||
			(sel == `EAU_OP_SHL) || (sel == `EAU_OP_MUY) || (sel == `EAU_OP_DVI);
	endfunction : op_legal

	// Operation select and datapath terms. The 13-bit sum keeps the carry of
	// each partial product, so twelve steps never overflow 24 bits.
	assign op       = instr[3:1];
	assign is_shift = (op == `EAU_OP_ASR) || (op == `EAU_OP_LSR) || (op == `EAU_OP_SHL);
	assign mul_sum  = {1'b0, ac} + (mq[0] ? {1'b0, operand} : 13'h0000);
	assign div_rem  = {ac, mq[11]};
	assign div_diff = div_rem - {1'b0, operand};
	assign div_fit  = div_rem >= {1'b0, operand};
	// Overflow compares the upper half alone, before any shift; testing the
	// shifted remainder would flag quotients that still fit in twelve bits.
	assign div_ovf  = {1'b0, ac} >= {1'b0, operand};
	assign tp_edge  = tp_sync & ~tp_prev;
	assign wr_en    = aph.sel & aph.write;
	assign start_wr = wr_en && (aph.addr == `EAU_ADDR_INSTR) && (state == EAU_IDLE) &&
		op_legal(hwdata[3:1]);
	assign status   = {19'h00000, subfield, state != EAU_IDLE, phase_five_hold,
		extension_timing_active, sc, link};

	////////////////////////////////////////////////////////////////////////////
	// Timing pulse synchroniser; the edge is taken between the later stages.

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tp_meta <= 1'b0;
			tp_sync <= 1'b0;
			tp_prev <= 1'b0;
		end else begin
			tp_meta <= third_timing_pulse;
			tp_sync <= tp_meta;
			tp_prev <= tp_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero wait states, always OKAY, read data registered.

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aph       <= '0;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			aph.sel   <= hsel && htrans[1] && hready && (hsize == 3'h2);
			aph.write <= hwrite;
			aph.addr  <= haddr[7:0];
			if (hsel && htrans[1] && hready && !hwrite) begin
				case (haddr[7:0])
					`EAU_ADDR_INSTR:   hrdata <= {20'h00000, instr};
					`EAU_ADDR_OPERAND: hrdata <= {20'h00000, operand};
					`EAU_ADDR_AC:      hrdata <= {20'h00000, ac};
					`EAU_ADDR_MQ:      hrdata <= {20'h00000, mq};
					`EAU_ADDR_STATUS:  hrdata <= status;
					default:           hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Instruction and memory buffer words; locked while an operation runs,
	// since the sequencer reads the operand through to the end.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			instr   <= `EAU_WORD_RST;
			operand <= `EAU_WORD_RST;
		end else if (wr_en && state == EAU_IDLE) begin
			if (start_wr) instr <= hwdata[11:0];
			if (aph.addr == `EAU_ADDR_OPERAND) operand <= hwdata[11:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer: takeover, counter load, stepping and hold release.

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state                   <= EAU_IDLE;
			sc                      <= `EAU_SC_RST;
			subfield                <= 4'h0;
			exec_flag               <= 1'b0;
			rel_cnt                 <= 2'h0;
			phase_five_hold         <= 1'b0;
			extension_timing_active <= 1'b0;
			multiplicand_add_enable <= 1'b0;
		end else begin
			case (state)
				EAU_IDLE: begin
					if (start_wr) state <= EAU_FETCH;
				end
				// Timing passes to the unit at the third pulse of fetch.
				EAU_FETCH: begin
					if (tp_edge) begin
						subfield        <= instr[3:0];
						exec_flag       <= 1'b1;
						phase_five_hold <= 1'b1;
						state           <= EAU_EXEC;
					end
				end
				EAU_EXEC: begin
					case (op)
						`EAU_OP_ASR, `EAU_OP_LSR: sc <= ~{1'b0, operand[3:0]};
						`EAU_OP_SHL:              sc <= ~operand[4:0];
						default:                  sc <= `EAU_SC_RST;
					endcase
					extension_timing_active <= 1'b1;
					state                   <= EAU_RUN;
				end
				EAU_RUN: begin
					multiplicand_add_enable <= (op == `EAU_OP_MUY) && mq[0];
					if (is_shift) begin
						// The last shift is the one made with the counter full.
						if (sc == `EAU_SC_FULL) state <= EAU_DONE;
						else sc <= sc + 5'h01;
					end else begin
						sc <= sc + 5'h01;
						if (op == `EAU_OP_MUY && sc == `EAU_MUY_END - 5'h01)
							state <= EAU_DONE;
						if (op == `EAU_OP_DVI && sc == `EAU_SC_RST && div_ovf)
							state <= EAU_DONE;
						if (op == `EAU_OP_DVI && sc == `EAU_DVI_END - 5'h01)
							state <= EAU_DONE;
					end
				end
				EAU_DONE: begin
					extension_timing_active <= 1'b0;
					multiplicand_add_enable <= 1'b0;
					exec_flag               <= 1'b0;
					rel_cnt                 <= 2'(`EAU_RELEASE_CYC);
					state                   <= EAU_RELEASE;
				end
				// The hold outlasts timing-active by the release delay.
				EAU_RELEASE: begin
					if (rel_cnt <= 2'h1) begin
						phase_five_hold <= 1'b0;
						state           <= EAU_IDLE;
					end else begin
						rel_cnt <= rel_cnt - 2'h1;
					end
				end
				default: state <= EAU_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Accumulator, extension register and carry: bus loads when idle,
	// otherwise one step of the selected operation per cycle in RUN.

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ac   <= `EAU_WORD_RST;
			mq   <= `EAU_WORD_RST;
			link <= 1'b0;
		end else if (state == EAU_IDLE) begin
			if (wr_en && aph.addr == `EAU_ADDR_AC) ac <= hwdata[11:0];
			if (wr_en && aph.addr == `EAU_ADDR_MQ) mq <= hwdata[11:0];
			if (wr_en && aph.addr == `EAU_ADDR_STATUS) link <= hwdata[`EAU_ST_LINK];
		end else if (state == EAU_FETCH && tp_edge && is_shift) begin
			link <= 1'b0;
		end else if (state == EAU_RUN) begin
			case (op)
				`EAU_OP_ASR: begin
					link <= ac[11];
					ac   <= {ac[11], ac[11:1]};
					mq   <= {ac[0], mq[11:1]};
				end
				`EAU_OP_LSR: begin
					link <= 1'b0;
					ac   <= {1'b0, ac[11:1]};
					mq   <= {ac[0], mq[11:1]};
				end
				`EAU_OP_SHL: begin
					link <= ac[11];
					ac   <= {ac[10:0], mq[11]};
					mq   <= {mq[10:0], 1'b0};
				end
				`EAU_OP_MUY: begin
					link <= 1'b0;
					ac   <= mul_sum[12:1];
					mq   <= {mul_sum[0], mq[11:1]};
				end
				`EAU_OP_DVI: begin
					// First pass only tests for overflow; then restoring steps.
					if (sc == `EAU_SC_RST) begin
						if (div_ovf) link <= 1'b1;
					end else begin
						link <= 1'b0;
						ac   <= div_fit ? div_diff[11:0] : div_rem[11:0];
						mq   <= {mq[10:0], div_fit};
					end
				end
				default: link <= link;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_mul_start;
		state == EAU_EXEC && op == `EAU_OP_MUY;
	endsequence
	sequence s_mul_end;
		state == EAU_DONE && sc == `EAU_MUY_END;
	endsequence

	property p_hold_run;
		state == EAU_RUN |-> phase_five_hold && extension_timing_active;
	endproperty
	a_hold_run: assert property (p_hold_run) else $error("Hold low while running.");

	property p_takeover;
		state == EAU_FETCH && tp_edge |=> state == EAU_EXEC && exec_flag && phase_five_hold;
	endproperty
	a_takeover: assert property (p_takeover) else $error("No takeover at pulse.");

	property p_fetch_link;
		state == EAU_FETCH && tp_edge && is_shift |=> !link && ac == $past(ac);
	endproperty
	a_fetch_link: assert property (p_fetch_link) else $error("Fetch carry not zeroed.");

	property p_sc_right;
		state == EAU_EXEC && op == `EAU_OP_ASR |=> sc == ~{1'b0, $past(operand[3:0])};
	endproperty
	a_sc_right: assert property (p_sc_right) else $error("Bad right shift count.");

	property p_asr_step;
		state == EAU_RUN && op == `EAU_OP_ASR |=> link == $past(ac[11]) && ac[11] == link;
	endproperty
	a_asr_step: assert property (p_asr_step) else $error("Sign not extended.");

	property p_lsr_step;
		state == EAU_RUN && op == `EAU_OP_LSR |=> !link && !ac[11] && mq[11] == $past(ac[0]);
	endproperty
	a_lsr_step: assert property (p_lsr_step) else $error("Bad logical shift.");

	property p_shl_step;
		state == EAU_RUN && op == `EAU_OP_SHL |=>
			link == $past(ac[11]) && ac[0] == $past(mq[11]) && !mq[0];
	endproperty
	a_shl_step: assert property (p_shl_step) else $error("Bad left shift.");

	property p_mul_twelve;
		s_mul_start |-> ##13 s_mul_end;
	endproperty
	a_mul_twelve: assert property (p_mul_twelve) else $error("Multiply not twelve steps.");

	property p_mul_add;
		state == EAU_RUN && op == `EAU_OP_MUY && mq[0] |=>
			{ac, mq[11]} == {1'b0, $past(ac)} + {1'b0, $past(operand)} &&
			multiplicand_add_enable;
	endproperty
	a_mul_add: assert property (p_mul_add) else $error("Multiplicand not added.");

	property p_shift_stop;
		state == EAU_RUN && is_shift && sc == `EAU_SC_FULL |=> state == EAU_DONE;
	endproperty
	a_shift_stop: assert property (p_shift_stop) else $error("Shift did not stop.");

	property p_div_ovf;
		state == EAU_RUN && op == `EAU_OP_DVI && sc == `EAU_SC_RST && div_ovf |=>
			state == EAU_DONE && link;
	endproperty
	a_div_ovf: assert property (p_div_ovf) else $error("Divide overflow missed.");

	property p_div_end;
		state == EAU_RUN && op == `EAU_OP_DVI && sc == `EAU_DVI_END - 5'h01 |=>
			state == EAU_DONE && sc == `EAU_DVI_END;
	endproperty
	a_div_end: assert property (p_div_end) else $error("Divide did not end at 13.");

	property p_release;
		state == EAU_DONE |=> !extension_timing_active && phase_five_hold ##1 !phase_five_hold;
	endproperty
	a_release: assert property (p_release) else $error("Hold release out of step.");

endmodule : eau_sequencer

`default_nettype wire

// ### test/eau_cpu_model.sv
// Processor timing model that drives the third timing pulse of each cycle.
// Assumes the unit's phase-five hold comes straight from the sequencer.
`default_nettype none

module eau_cpu_model (
	// Clock and reset.
	input  wire logic hclk,
	input  wire logic hresetn,
	// Timing handshake with the unit.
	input  wire logic phase_five_hold,
	output var  logic third_timing_pulse
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [2:0] phase;

	// Eight-cycle processor cycle with the pulse high in two of them.
	// While held, the cycle is kept at phase zero and restarts only once released.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase              <= 3'h0;
			third_timing_pulse <= 1'b0;
		end else if (phase_five_hold) begin
			phase              <= 3'h0;
			third_timing_pulse <= 1'b0;
		end else begin
			phase              <= phase + 3'h1;
			third_timing_pulse <= (phase == 3'h2) || (phase == 3'h3);
		end
	end
endmodule : eau_cpu_model

`default_nettype wire

// ### test/eau_sequencer_test.sv
// Self-checking bench of the sequencer, registers reached over AHB-Lite.
// Assumes the processor timing model of eau_cpu_model at the pulse pin.
`default_nettype none

module eau_sequencer_test;
	timeunit 1ns;
	timeprecision 1ns;

	logic        hclk, hresetn, hsel, hwrite, hready, hresp, tp, hold, act, mae;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	int          errors, cmp_count, act_n, mae_n, tail_n, bad_n;

	eau_sequencer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.third_timing_pulse(tp), .phase_five_hold(hold),
		.extension_timing_active(act), .multiplicand_add_enable(mae));
	eau_cpu_model i_cpu (.hclk(hclk), .hresetn(hresetn), .phase_five_hold(hold),
		.third_timing_pulse(tp));

	// Clock of 100 ns.
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	// Timing watch; counts are cleared by run_op just before each start write.
	always @(posedge hclk) begin
		if (act === 1'b1) act_n++;
		if (mae === 1'b1) mae_n++;
		if (hold === 1'b1 && act !== 1'b1) tail_n++;
		if (act === 1'b1 && hold !== 1'b1) bad_n++;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : test_done

	task automatic chk_val(input string nm, input logic [31:0] exp, got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s: expected %h, seen %h", nm, exp, got);
		end
	endtask : chk_val

	task automatic chk_cnt(input string nm, input int exp, got);
		cmp_count++;
		if (got != exp) begin
			errors++;
			$display("wrong value %s: expected %0d, seen %0d", nm, exp, got);
		end
	endtask : chk_cnt

	// Waits for hready high at an edge; a stuck bus ends the run.
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			test_done();
		end
	endtask : wait_rdy

	// One single word transfer; read data lands in rd.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= w ? wd : 32'h0;
		wait_rdy();
		rd = hrdata;
	endtask : xfer

	// Polls the busy bit under a bound.
	task automatic wait_idle;
		int n;
		for (n = 0; n < 300; n++) begin
			xfer(1'b0, 8'h10, 32'h0);
			if (rd[8] === 1'b0) return;
		end
		errors++;
		test_done();
	endtask : wait_idle

	// Loads the operands, starts one operation and waits for its end.
	// The accumulator write while busy must be ignored.
	task automatic run_op(input logic [11:0] ins, op, ac0, mq0, input logic lk);
		xfer(1'b1, 8'h08, {20'h0, ac0});
		xfer(1'b1, 8'h0c, {20'h0, mq0});
		xfer(1'b1, 8'h10, {31'h0, lk});
		xfer(1'b1, 8'h04, {20'h0, op});
		act_n  = 0;
		mae_n  = 0;
		tail_n = 0;
		bad_n  = 0;
		xfer(1'b1, 8'h00, {20'h0, ins});
		xfer(1'b1, 8'h08, 32'h555);
		wait_idle();
	endtask : run_op

	task automatic check(input logic [11:0] ac, mq, input logic lk, input int steps, adds);
		xfer(1'b0, 8'h08, 32'h0);
		chk_val("ac", {20'h0, ac}, rd);
		xfer(1'b0, 8'h0c, 32'h0);
		chk_val("mq", {20'h0, mq}, rd);
		xfer(1'b0, 8'h10, 32'h0);
		chk_val("link", {31'h0, lk}, {31'h0, rd[0]});
		chk_cnt("timing cycles", steps + 1, act_n);
		chk_cnt("add cycles", adds, mae_n);
		chk_cnt("hold tail", 2, tail_n);
		chk_cnt("unheld cycles", 0, bad_n);
	endtask : check

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk_val("hresp", 32'h0, {31'h0, hresp});
		xfer(1'b0, 8'h10, 32'h0);
		chk_val("status", 32'h0, rd);
		xfer(1'b0, 8'h14, 32'h0);
		chk_val("unmapped", 32'h0, rd);
		xfer(1'b1, 8'h00, 32'hf01);
		xfer(1'b0, 8'h10, 32'h0);
		chk_val("busy", 32'h0, rd);
		$display("test reset done");
	endtask : t_reset

	task automatic t_shifts;
		logic [23:0] p;
		logic [24:0] v;
		p = $signed(24'h800001) >>> 3;
		run_op(12'hf0d, 12'hff2, 12'h800, 12'h001, 1'b0);
		check(p[23:12], p[11:0], 1'b1, 3, 0);
		p = 24'hfff000 >> 16;
		run_op(12'hf0f, 12'h00f, 12'hfff, 12'h000, 1'b1);
		check(p[23:12], p[11:0], 1'b0, 16, 0);
		v = {1'b0, 24'h401801} << 17;
		run_op(12'hf0b, 12'h010, 12'h401, 12'h801, 1'b1);
		check(v[23:12], v[11:0], v[24], 17, 0);
		$display("test shifts done");
	endtask : t_shifts

	task automatic t_multiply;
		logic [23:0] p;
		p = 24'h000fff * 24'h000fff;
		run_op(12'hf05, 12'hfff, 12'h000, 12'hfff, 1'b0);
		check(p[23:12], p[11:0], 1'b0, 12, 12);
		p = 24'h00000c * 24'h00000c;
		run_op(12'hf05, 12'h00c, 12'h000, 12'h00c, 1'b0);
		check(p[23:12], p[11:0], 1'b0, 12, 2);
		$display("test multiply done");
	endtask : t_multiply

	task automatic t_divide;
		logic [23:0] q, r;
		run_op(12'hf07, 12'h005, 12'h005, 12'h123, 1'b0);
		check(12'h005, 12'h123, 1'b1, 1, 0);
		q = 24'h001234 / 24'h000100;
		r = 24'h001234 % 24'h000100;
		run_op(12'hf07, 12'h100, 12'h001, 12'h234, 1'b0);
		check(r[11:0], q[11:0], 1'b0, 13, 0);
		q = 24'h080fff / 24'h000100;
		r = 24'h080fff % 24'h000100;
		run_op(12'hf07, 12'h100, 12'h080, 12'hfff, 1'b0);
		check(r[11:0], q[11:0], 1'b0, 13, 0);
		$display("test divide done");
	endtask : t_divide

	// Main sequence: reset for ten cycles, then the scenarios.
	initial begin
		hresetn   = 1'b0;
		hsel      = 1'b0;
		haddr     = 32'h0;
		htrans    = 2'h0;
		hwrite    = 1'b0;
		hsize     = 3'h2;
		hwdata    = 32'h0;
		errors    = 0;
		cmp_count = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_shifts();
		t_multiply();
		t_divide();
		test_done();
	end
endmodule : eau_sequencer_test

`default_nettype wire
